// ===== logic/icd_decoder.sv
// Instruction decoder with cycle counting and no-op insertion
`timescale 1ns/1ps
module icd_decoder
   import icd_pkg::*;
(
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst_n,
   // Program memory word, execution feedback and clock output select
   input  wire logic [WORD_W-1:0]  instr_word,
   input  wire logic               cond_true,
   input  wire logic               clock_output_pin_sel,
   // Decoded instruction
   output icd_dec_t                dec_reg,
   output logic [WORD_W-1:0]       ext_word_reg,
   output logic [CYC_W-1:0]        cycles_reg,
   // Cycle strobes
   output logic                    exec_valid_reg,
   output logic                    exec_nop_reg,
   output logic                    ext_valid_reg,
   // Clock output
   output logic                    clock_output_pin
);
   typedef enum logic [1:0] {ST_DECODE, ST_EXT, ST_FLUSH} icd_state_t;

   icd_state_t       state_reg;
   logic [1:0]       flush_cnt_reg;
   logic             skip_reg;
   logic             cy_en;
   icd_class_t       cur_cls;
   logic [1:0]       extra_next;
   logic             skip_long;

   // Opcode classification; also used on words being squashed
   function automatic icd_class_t cls_f(input logic [OPC_W-1:0] op);
      icd_class_t c;
      c = CL_NOP;
      case (op[7:4])
         GRP_WORKING_REG_ZERO_ALIAS:   c = CL_WORKING_REG_ZERO_ALIAS;
         GRP_FILE:   c = CL_FILE;
         GRP_BITLIT: c = CL_BIT_LIT;
         GRP_BITIND: c = CL_BIT_IND;
         GRP_LITALU: c = CL_LIT_ALU;
         GRP_LITMOV: c = CL_LIT_MOV;
         default:    c = CL_NOP;
      endcase
      case (op)
         OP_BRA_COND:   c = CL_BRA_COND;
         OP_SKIP:       c = CL_SKIP;
         OP_BRA_ALWAYS: c = CL_BRA_ALWAYS;
         OP_CALL_IND,
         OP_GOTO_IND:   c = CL_JUMP_IND;
         OP_TBL_RD,
         OP_TBL_WR:     c = CL_TABLE;
         OP_RETURN:     c = CL_RETURN;
         OP_IRET:       c = CL_IRET;
         OP_GOTO_LONG,
         OP_CALL_LONG,
         OP_MOV_DBL:    c = CL_TWO_WORD;
         default:       c = c;
      endcase
      return c;
   endfunction

   // Operand split; every field is filled, class says which are meaningful
   function automatic icd_dec_t dec_f(input logic [WORD_W-1:0] w);
      icd_dec_t d;
      d = '0;
      d.opcode            = w[OPC_LSB +: OPC_W];
      d.cls               = cls_f(d.opcode);
      d.base_source_reg   = w[BASE_LSB +: REG_W];
      d.second_source_reg = w[SRC_LSB +: REG_W];
      d.second_mode       = w[SMODE_LSB +: MODE_W];
      d.result_dest_reg   = w[DEST_LSB +: REG_W];
      d.dest_mode         = w[DMODE_LSB +: MODE_W];
      d.file_addr         = w[FADDR_LSB +: FADDR_W];
      d.working_reg_zero_alias = (d.cls == CL_FILE) && w[DSEL_BIT];
      d.on_file           = w[ONFILE_BIT];
      d.bit_pos           = w[BASE_LSB +: REG_W];
      d.bit_from_reg      = (d.cls == CL_BIT_IND);
      d.literal           = w[LIT_LSB +: LIT_W];
      if (d.cls == CL_BIT_IND)
      begin
         d.bit_pos = '0; // Position taken from base register contents
      end
      if (d.cls == CL_LIT_ALU)
      begin
         // Without the separate flag the result returns to the base
         d.second_mode = '0;
         d.dest_mode   = '0;
         d.result_dest_reg = w[DSEP_BIT] ? w[SRC_LSB +: REG_W]
                                         : w[BASE_LSB +: REG_W];
      end
      return d;
   endfunction

   icd_phase u_phase (
      .clk              (clk),
      .rst_n            (rst_n),
      .clock_output_pin_sel         (clock_output_pin_sel),
      .cy_en            (cy_en),
      .clock_output_pin (clock_output_pin)
   );

   // Extra no-op cycles owed by the word now being decoded
   always_comb
   begin
      cur_cls    = cls_f(instr_word[OPC_LSB +: OPC_W]);
      extra_next = 2'h0;
      case (cur_cls)
         CL_BRA_ALWAYS,
         CL_JUMP_IND,
         CL_TABLE:    extra_next = 2'h1;
         CL_RETURN,
         CL_IRET:     extra_next = 2'h2;
         CL_BRA_COND,
         CL_SKIP:     extra_next = cond_true ? 2'h1 : 2'h0;
         default:     extra_next = 2'h0;
      endcase
   end

   // A skipped first word of a two-word form drags its second word along
   assign skip_long = skip_reg && (cur_cls == CL_TWO_WORD);

   // Sequencing of decode, second word and squashed cycles
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg     <= ST_DECODE;
         flush_cnt_reg <= 2'h0;
         skip_reg      <= 1'b0;
      end
      else if (cy_en)
      begin
         case (state_reg)
            ST_DECODE:
            begin
               skip_reg      <= (cur_cls == CL_SKIP) && cond_true;
               flush_cnt_reg <= extra_next;
               if (cur_cls == CL_TWO_WORD)
               begin
                  state_reg <= ST_EXT;
               end
               else if (extra_next != 2'h0)
               begin
                  state_reg <= ST_FLUSH;
               end
            end
            ST_EXT:
            begin
               state_reg <= ST_DECODE;
            end
            ST_FLUSH:
            begin
               skip_reg <= 1'b0;
               if (!skip_long)
               begin
                  flush_cnt_reg <= flush_cnt_reg - 2'h1;
                  if (flush_cnt_reg == 2'h1)
                  begin
                     state_reg <= ST_DECODE;
                  end
               end
            end
            default:
            begin
               state_reg <= ST_DECODE;
            end
         endcase
      end
   end

   // Strobes; a squashed word only ever shows as exec_nop
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         exec_valid_reg <= 1'b0;
         exec_nop_reg   <= 1'b0;
         ext_valid_reg  <= 1'b0;
      end
      else
      begin
         exec_valid_reg <= cy_en && (state_reg == ST_DECODE);
         exec_nop_reg   <= cy_en && (state_reg == ST_FLUSH);
         ext_valid_reg  <= cy_en && (state_reg == ST_EXT);
      end
   end

   // Decoded fields and the extension word
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dec_reg      <= '0;
         ext_word_reg <= '0;
      end
      else if (cy_en)
      begin
         if (state_reg == ST_DECODE)
         begin
            dec_reg <= dec_f(instr_word);
         end
         if (state_reg == ST_EXT)
         begin
            ext_word_reg <= instr_word;
         end
      end
   end

   // Cycle total; a long skip adds its third cycle one cycle later
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cycles_reg <= CYC_ONE;
      end
      else if (cy_en)
      begin
         if (state_reg == ST_DECODE)
         begin
            cycles_reg <= (cur_cls == CL_TWO_WORD) ? CYC_TWO
                          : CYC_ONE + extra_next;
         end
         else if (state_reg == ST_FLUSH && skip_long)
         begin
            cycles_reg <= CYC_THREE;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_nop_issue;
      ##2 exec_nop_reg ##2 exec_valid_reg;
   endsequence

   sequence s_two_nops;
      ##2 exec_nop_reg ##2 exec_nop_reg ##2 exec_valid_reg;
   endsequence

   a_cycle_period: assert property (cy_en |=> !cy_en ##1 cy_en)
      else $error("instruction cycle is not two clocks");
   a_clock_output_pin_phase: assert property (##1 clock_output_pin == ($past(clock_output_pin_sel) && cy_en))
      else $error("clock output not in phase with cycle halves");
   a_clock_output_pin_div: assert property (clock_output_pin_sel [*3]
      |-> clock_output_pin != $past(clock_output_pin))
      else $error("clock output not oscillator divided by two");
   a_one_cycle: assert property (exec_valid_reg && cycles_reg == CYC_ONE
      && dec_reg.cls != CL_TWO_WORD |-> ##2 exec_valid_reg)
      else $error("single cycle instruction not followed by next issue");
   a_taken_nop: assert property (exec_valid_reg && cycles_reg == CYC_TWO
      && dec_reg.cls != CL_SKIP && dec_reg.cls != CL_TWO_WORD |-> s_nop_issue)
      else $error("two cycle instruction lacks its no-op cycle");
   a_return_three: assert property (exec_valid_reg && (dec_reg.cls == CL_RETURN
      || dec_reg.cls == CL_IRET) |-> cycles_reg == CYC_THREE ##0 s_two_nops)
      else $error("return does not take three cycles");
   a_skip_cost: assert property (exec_valid_reg && dec_reg.cls == CL_SKIP
      && cycles_reg == CYC_TWO |-> ##2 exec_nop_reg ##2
      (exec_valid_reg || (exec_nop_reg && cycles_reg == CYC_THREE)))
      else $error("taken skip cost wrong");
   a_two_word: assert property (exec_valid_reg && dec_reg.cls == CL_TWO_WORD
      |-> cycles_reg == CYC_TWO ##2 ext_valid_reg ##2 exec_valid_reg)
      else $error("two-word instruction not two cycles");
   a_file_dest: assert property (exec_valid_reg && dec_reg.cls == CL_FILE
      |-> dec_reg.working_reg_zero_alias == $past(instr_word[DSEL_BIT]))
      else $error("file destination selector wrong");
   a_lit_dest: assert property (exec_valid_reg && dec_reg.cls == CL_LIT_ALU
      && !$past(instr_word[DSEP_BIT])
      |-> dec_reg.result_dest_reg == dec_reg.base_source_reg)
      else $error("literal op destination not base register");
endmodule

// ===== logic/icd_phase.sv
// Instruction cycle phase divider and clock output flop
`timescale 1ns/1ps
module icd_phase
   import icd_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Control
   input  wire logic clock_output_pin_sel,
   // Phase outputs
   output logic      cy_en,
   output logic      clock_output_pin
);
   logic phase_next;

   // Low half is phases one and two, high half is three and four
   assign phase_next = ~cy_en;

   // Divide by two; cy_en high in the second half marks the cycle end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cy_en <= 1'b0;
      end
      else
      begin
         cy_en <= phase_next;
      end
   end

   // Pin is forced low when the output function is not selected
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clock_output_pin <= 1'b0;
      end
      else
      begin
         clock_output_pin <= clock_output_pin_sel & phase_next;
      end
   end
endmodule

// ===== logic/icd_pkg.sv
// Shared constants, field layout and types of the instruction cycle decoder
// Overview of operation
// - Each plain instruction is 24 bits, top 8 bits being the opcode.
// - Almost all instructions are one word; three forms take a second word.
// - Two-word forms hold 48 bits; second word top 8 zero runs as no-op.
// - Plain instructions take one cycle, two when a test is true or PC changes.
// - Branch, indirect jumps, table access and returns take two or three cycles.
// - Taken skip costs two cycles, three when the skipped one is two words.
// - Every two-word instruction finishes in exactly two cycles.
// - Register ops decode base, modifiable second source and modifiable destination.
// - File ops decode file address and selector for file or register zero.
// - Bit ops address register or file, bit from literal or base register.
// - Literal ALU ops decode separate destination only when not the base.
// - One instruction cycle lasts two oscillator periods.
// - Clock output low in the first half cycle, high in the second.
// - When selected, the clock output pin carries the oscillator divided by two.
package icd_pkg;
   localparam int WORD_W    = 24;
   localparam int OPC_W     = 8;
   localparam int OPC_LSB   = 16;
   localparam int REG_W     = 4;
   localparam int MODE_W    = 2;
   localparam int FADDR_W   = 11;
   localparam int LIT_W     = 7;
   localparam int CYC_W     = 2;
   localparam int PHASE_W   = 1;
   // Operand field positions
   localparam int BASE_LSB  = 12;
   localparam int DEST_LSB  = 8;
   localparam int DMODE_LSB = 6;
   localparam int SMODE_LSB = 4;
   localparam int SRC_LSB   = 0;
   localparam int FADDR_LSB = 0;
   localparam int DSEL_BIT  = 13;
   localparam int ONFILE_BIT = 11;
   localparam int DSEP_BIT  = 11;
   localparam int LIT_LSB   = 4;
   // Opcodes of control forms; values are arbitrary
   localparam logic [7:0] OP_NOP       = 8'h00;
   localparam logic [7:0] OP_BRA_ALWAYS = 8'h70;
   localparam logic [7:0] OP_BRA_COND  = 8'h71;
   localparam logic [7:0] OP_SKIP      = 8'h72;
   localparam logic [7:0] OP_CALL_IND  = 8'h73;
   localparam logic [7:0] OP_GOTO_IND  = 8'h74;
   localparam logic [7:0] OP_TBL_RD    = 8'h75;
   localparam logic [7:0] OP_TBL_WR    = 8'h76;
   localparam logic [7:0] OP_RETURN    = 8'h77;
   localparam logic [7:0] OP_IRET      = 8'h78;
   localparam logic [7:0] OP_GOTO_LONG = 8'h80;
   localparam logic [7:0] OP_CALL_LONG = 8'h81;
   localparam logic [7:0] OP_MOV_DBL   = 8'h82;
   // Upper opcode nibble of data forms
   localparam logic [3:0] GRP_WORKING_REG_ZERO_ALIAS   = 4'h1;
   localparam logic [3:0] GRP_FILE   = 4'h2;
   localparam logic [3:0] GRP_BITLIT = 4'h3;
   localparam logic [3:0] GRP_BITIND = 4'h4;
   localparam logic [3:0] GRP_LITALU = 4'h5;
   localparam logic [3:0] GRP_LITMOV = 4'h6;
   // Instruction cycle counts
   localparam logic [1:0] CYC_ONE   = 2'h1;
   localparam logic [1:0] CYC_TWO   = 2'h2;
   localparam logic [1:0] CYC_THREE = 2'h3;

   typedef enum logic [3:0] {
      CL_NOP, CL_WORKING_REG_ZERO_ALIAS, CL_FILE, CL_BIT_LIT, CL_BIT_IND, CL_LIT_ALU,
      CL_LIT_MOV, CL_BRA_COND, CL_SKIP, CL_BRA_ALWAYS, CL_JUMP_IND,
      CL_TABLE, CL_RETURN, CL_IRET, CL_TWO_WORD
   } icd_class_t;

   typedef struct packed {
      logic [OPC_W-1:0]   opcode;
      icd_class_t         cls;
      logic [REG_W-1:0]   base_source_reg;
      logic [REG_W-1:0]   second_source_reg;
      logic [MODE_W-1:0]  second_mode;
      logic [REG_W-1:0]   result_dest_reg;
      logic [MODE_W-1:0]  dest_mode;
      logic [FADDR_W-1:0] file_addr;
      logic               working_reg_zero_alias;
      logic               on_file;
      logic [REG_W-1:0]   bit_pos;
      logic               bit_from_reg;
      logic [LIT_W-1:0]   literal;
   } icd_dec_t;
endpackage

// ===== test/icd_prog_mem.sv
// Program memory model feeding one word per instruction cycle to the decoder
`timescale 1ns/1ps
module icd_prog_mem
   import icd_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // Word stream
   output logic [WORD_W-1:0]      instr_word,
   output logic                   cond_true
);
   logic [WORD_W-1:0] mem [0:31];
   logic              cnd [0:31];
   logic [4:0]        pc_reg;
   logic              ph_reg;

   // Start from an all-no-op image so nothing is unknown at time zero
   initial
   begin
      for (int i = 0; i < 32; i++)
      begin
         mem[i] = '0;
         cnd[i] = 1'h0;
      end
   end

   // Mirror of the two-clock instruction cycle; never stalls, one word per cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ph_reg <= 1'h0;
         pc_reg <= 5'h0;
      end
      else
      begin
         ph_reg <= ~ph_reg;
         if (ph_reg)
            pc_reg <= pc_reg + 5'h1;
      end
   end

   // Whole 24-bit word and its condition leave together
   assign instr_word = mem[pc_reg];
   assign cond_true  = cnd[pc_reg];
endmodule

// ===== test/tb_icd_decoder.sv
// Self-checking bench of the instruction decoder
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); end end
module tb_icd_decoder
   import icd_pkg::*;
;
   logic              clk = 1'h0;
   logic              rst_n = 1'h0;
   logic              clock_output_pin_sel = 1'h0;
   logic [WORD_W-1:0] instr_word;
   logic              cond_true;
   icd_dec_t          dec;
   logic [WORD_W-1:0] ext_word;
   logic [CYC_W-1:0]  cycles;
   logic              exec_valid;
   logic              exec_nop;
   logic              ext_valid;
   logic              pin;
   int                err_total = 0;
   int                n_compared = 0;
   logic [4:0]        exp_s [0:31];
   logic [4:0]        got_s [0:31];
   logic [7:0]        eop [0:31];
   icd_dec_t          gd [0:31];
   logic [WORD_W-1:0] gx [0:31];
   logic [1:0]        mid [0:31];
   logic              lo [0:31];

   // Clock of 40 ns
   always #20 clk = ~clk;

   icd_prog_mem pm (.clk(clk), .rst_n(rst_n), .instr_word(instr_word), .cond_true(cond_true));

   icd_decoder dut (
      .clk             (clk),
      .rst_n           (rst_n),
      .instr_word      (instr_word),
      .cond_true       (cond_true),
      .clock_output_pin_sel        (clock_output_pin_sel),
      .dec_reg         (dec),
      .ext_word_reg    (ext_word),
      .cycles_reg      (cycles),
      .exec_valid_reg  (exec_valid),
      .exec_nop_reg    (exec_nop),
      .ext_valid_reg   (ext_valid),
      .clock_output_pin(pin)
   );

   function automatic logic [4:0] ev(input logic v, n, x, input logic [1:0] c);
      return {v, n, x, c};
   endfunction

   task complete_run;
      $display("compared %0d, mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task clr;
      for (int i = 0; i < 32; i++)
      begin
         pm.mem[i] = '0;
         pm.cnd[i] = 1'h0;
         exp_s[i] = '0;
      end
   endtask

   // Load a slot; the decoded opcode only moves on an issued word
   task ld(input int i, input logic [WORD_W-1:0] w, input logic c, input logic [4:0] e);
      pm.mem[i] = w;
      pm.cnd[i] = c;
      exp_s[i] = e;
      eop[i] = e[4] ? w[23:16] : eop[i-1];
   endtask

   // Reset for two clocks, then record outputs mid-cycle and after each sampling edge
   task play(input int n, input logic sel);
      @(posedge clk);
      rst_n <= 1'h0;
      clock_output_pin_sel <= sel;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         #1 mid[i] = {exec_valid, pin};
         @(posedge clk);
         #1 got_s[i] = {exec_valid, exec_nop, ext_valid, cycles};
         gd[i] = dec;
         gx[i] = ext_word;
         lo[i] = pin;
      end
   endtask

   task t_data;
      icd_dec_t dw;
      clr();
      ld(0, {8'h10, 16'h5abc}, 1'h0, ev(1, 0, 0, CYC_ONE));
      ld(1, {8'h20, 16'h27ff}, 1'h0, ev(1, 0, 0, CYC_ONE));
      ld(2, {8'h30, 16'h9800}, 1'h0, ev(1, 0, 0, CYC_ONE));
      ld(3, {8'h40, 16'h6000}, 1'h0, ev(1, 0, 0, CYC_ONE));
      ld(4, {8'h50, 16'h3ab7}, 1'h0, ev(1, 0, 0, CYC_ONE));
      ld(5, {8'h50, 16'h4123}, 1'h0, ev(1, 0, 0, CYC_ONE));
      ld(6, 24'h001234, 1'h0, ev(1, 0, 0, CYC_ONE));
      play(7, 1'h0);
      for (int i = 0; i < 7; i++)
      begin
         `CHK(got_s[i], exp_s[i])
         `CHK(gd[i].opcode, eop[i])
      end
      dw = gd[0];
      `CHK({dw.cls, dw.base_source_reg, dw.result_dest_reg}, {CL_WORKING_REG_ZERO_ALIAS, 8'h5a})
      `CHK({dw.dest_mode, dw.second_mode, dw.second_source_reg}, 8'hbc)
      dw = gd[1];
      `CHK({dw.cls, dw.working_reg_zero_alias, dw.file_addr}, {CL_FILE, 1'h1, 11'h7ff})
      dw = gd[2];
      `CHK({dw.cls, dw.bit_pos, dw.bit_from_reg, dw.on_file}, {CL_BIT_LIT, 4'h9, 2'h1})
      dw = gd[3];
      `CHK({dw.cls, dw.base_source_reg, dw.bit_from_reg, dw.on_file}, {CL_BIT_IND, 4'h6, 2'h2})
      dw = gd[4];
      `CHK({dw.cls, dw.base_source_reg, dw.literal}, {CL_LIT_ALU, 4'h3, 7'h2b})
      `CHK(dw.result_dest_reg, 4'h7)
      dw = gd[5];
      `CHK({dw.base_source_reg, dw.literal, dw.result_dest_reg}, {4'h4, 7'h12, 4'h4})
      `CHK(gd[6].cls, CL_NOP)
   endtask

   // Every control form but skip and the two-word ones, each followed by words that must be squashed
   task t_ctrl;
      logic [7:0] ops [0:7];
      int         s;
      ops = '{OP_BRA_ALWAYS, OP_CALL_IND, OP_GOTO_IND, OP_TBL_RD, OP_TBL_WR, OP_BRA_COND,
              OP_RETURN, OP_IRET};
      s = 0;
      clr();
      for (int k = 0; k < 8; k++)
      begin
         ld(s, {ops[k], 16'h0000}, 1'h1, ev(1, 0, 0, k < 6 ? CYC_TWO : CYC_THREE));
         s++;
         for (int j = 0; j < (k < 6 ? 1 : 2); j++)
         begin
            ld(s, {8'h10, 16'hffff}, 1'h0, ev(0, 1, 0, k < 6 ? CYC_TWO : CYC_THREE));
            s++;
         end
      end
      ld(s, {OP_BRA_COND, 16'h0000}, 1'h0, ev(1, 0, 0, CYC_ONE));
      ld(s + 1, {8'h10, 16'h1111}, 1'h0, ev(1, 0, 0, CYC_ONE));
      play(s + 2, 1'h0);
      for (int i = 0; i < s + 2; i++)
      begin
         `CHK(got_s[i], exp_s[i])
         `CHK(gd[i].opcode, eop[i])
      end
   endtask

   // Two-word forms, then skips over one- and two-word instructions
   task t_two;
      clr();
      ld(0, {OP_GOTO_LONG, 16'h0123}, 1'h0, ev(1, 0, 0, CYC_TWO));
      ld(1, 24'h00abcd, 1'h0, ev(0, 0, 1, CYC_TWO));
      ld(2, {OP_CALL_LONG, 16'h0456}, 1'h0, ev(1, 0, 0, CYC_TWO));
      ld(3, 24'h005a5a, 1'h0, ev(0, 0, 1, CYC_TWO));
      ld(4, {OP_MOV_DBL, 16'h0789}, 1'h0, ev(1, 0, 0, CYC_TWO));
      ld(5, 24'h00c3c3, 1'h0, ev(0, 0, 1, CYC_TWO));
      ld(6, {OP_SKIP, 16'h0000}, 1'h1, ev(1, 0, 0, CYC_TWO));
      ld(7, {8'h10, 16'h2222}, 1'h0, ev(0, 1, 0, CYC_TWO));
      ld(8, {OP_SKIP, 16'h0000}, 1'h1, ev(1, 0, 0, CYC_TWO));
      ld(9, {OP_GOTO_LONG, 16'h0000}, 1'h0, ev(0, 1, 0, CYC_THREE));
      ld(10, 24'h00ffff, 1'h0, ev(0, 1, 0, CYC_THREE));
      ld(11, {OP_SKIP, 16'h0000}, 1'h0, ev(1, 0, 0, CYC_ONE));
      ld(12, {8'h10, 16'h3333}, 1'h0, ev(1, 0, 0, CYC_ONE));
      play(13, 1'h0);
      for (int i = 0; i < 6; i++)
         `CHK(got_s[i], exp_s[i])
      for (int i = 6; i < 13; i++)
         `CHK(got_s[i], exp_s[i])
      for (int i = 0; i < 13; i++)
         `CHK(gd[i].opcode, eop[i])
      `CHK({gx[1], gx[3], gx[5]}, {24'h00abcd, 24'h005a5a, 24'h00c3c3})
   endtask

   // Clock output with the function selected, then deselected
   task t_clock;
      clr();
      for (int i = 0; i < 8; i++)
         ld(i, {8'h10, 16'h4444}, 1'h0, ev(1, 0, 0, CYC_ONE));
      play(8, 1'h1);
      for (int i = 0; i < 8; i++)
      begin
         `CHK(got_s[i], exp_s[i])
         `CHK({mid[i], lo[i]}, 3'h2)
      end
      play(4, 1'h0);
      for (int i = 0; i < 4; i++)
         `CHK({mid[i], lo[i]}, 3'h0)
   endtask

   // Cut a hang short
   initial
   begin
      #100000;
      err_total++;
      complete_run();
   end

   // Let the model clear its image first so the loaded program is not wiped
   initial
   begin
      #1;
      clr();
      t_data();
      t_ctrl();
      t_two();
      t_clock();
      complete_run();
   end
endmodule
